// ===== hdl/tps_pkg.sv
package tps_pkg;
  // blink half period: 250 ms at 125 MHz
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MS;
  // power-up title and beep times
  localparam int unsigned TITLE_MS = 3000;
  localparam int unsigned TITLE_CYCLES = (CLK_HZ / 1000) * TITLE_MS;
  localparam int unsigned BEEP_MS = 100;
  localparam int unsigned BEEP_CYCLES = (CLK_HZ / 1000) * BEEP_MS;
  localparam int CNT_W = 32;
  // settings word width held in the small store
  localparam int SET_W = 16;
  localparam logic [SET_W-1:0] SET_RESET = 16'h0000;
  // latched fault bit positions
  localparam int F_THI = 0;
  localparam int F_TLO = 1;
  localparam int F_RLIM = 2;
  localparam int F_OPEN = 3;
  localparam int F_SOPEN = 4;
  localparam int F_SSEL = 5;
  localparam int F_SSHORT = 6;
  localparam int F_MODE = 7;
  localparam int NFAULT = 8;
  localparam logic [NFAULT-1:0] FAULT_RESET = 8'h00;

  typedef enum logic [1:0] {
    TPS_MODE_TEMP,
    TPS_MODE_RES,
    TPS_MODE_ITE
  } tps_mode_t;

  // raw sense inputs from the comparators
  typedef struct packed {
    logic temp_high;
    logic temp_low;
    logic res_limit;
    logic load_open;
    logic sensor_open;
    logic sensor_short;
    logic sensor_sel_change;
    logic current_limit;
    logic internal_over;
    logic internal_warn;
    logic compliance_over;
    logic interlock_joined;
    logic sensor_none;
  } tps_sense_t;

  // indicator outputs
  typedef struct packed {
    logic error_led;
    logic limit_led;
    logic on_led;
  } tps_leds_t;
endpackage

// ===== hdl/tps_store.sv
`timescale 1ns/1ps
// settings kept across power cycles; read data registered
module tps_store (
  // clock
  input wire logic clk,
  // write side
  input wire logic wr,
  input wire logic [tps_pkg::SET_W-1:0] wdata,
  // read side
  output logic [tps_pkg::SET_W-1:0] rdata
);
  logic [tps_pkg::SET_W-1:0] mem; // no reset: survives the power-on reset

  // store on save
  always_ff @(posedge clk) begin
    if (wr) begin
      mem <= wdata;
    end
  end

  // registered read
  always_ff @(posedge clk) begin
    rdata <= mem;
  end
endmodule

// ===== hdl/tps_top.sv
`timescale 1ns/1ps
// Operation
// - listed faults force output off, error on
// - error clears only after fix and on-request
// - over limit clamps current, limit LED blinks
// - limit LED off once current within limit
// - hard conditions light both LEDs steadily
// - warning temperature while on blinks error, maybe limit
// - limiting alone blinks only limit LED
// - no condition keeps both LEDs off
// - power-up restores settings, output off, title, beep
// - on-request lights on LED; interlock gates drive, not the LED
// - inverted polarity needs interlock pins joined
// - mode press while on disables, errors, advances
// - current mode enforces temp limits unless none
module tps_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sense inputs
  input wire tps_pkg::tps_sense_t sense,
  // front panel
  input wire logic output_on_req,
  input wire logic output_off_req,
  input wire logic mode_press,
  input wire logic beeper_enable,
  // hardware_config_command polarity write
  input wire logic hardware_config_command,
  input wire logic interlock_invert_in,
  // settings save request and data
  input wire logic save_settings,
  input wire logic [tps_pkg::SET_W-1:0] settings_in,
  // outputs
  output tps_pkg::tps_leds_t leds,
  output logic drive_enable,
  output logic current_clamp,
  output logic title_show,
  output logic beep,
  output logic [tps_pkg::SET_W-1:0] settings_out,
  output tps_pkg::tps_mode_t mode,
  output logic [tps_pkg::NFAULT-1:0] fault_flags
);
  logic interlock_invert; // sense polarity
  logic out_en; // output requested on
  logic [tps_pkg::NFAULT-1:0] next_fault; // raw fault vector
  logic [tps_pkg::SET_W-1:0] store_rdata; // restored settings
  logic [tps_pkg::CNT_W-1:0] blink_cnt; // blink timer
  logic blink; // blink phase
  logic [tps_pkg::CNT_W-1:0] title_cnt; // title timer
  logic [tps_pkg::CNT_W-1:0] beep_cnt; // beep timer
  logic boot; // first cycle after reset
  logic restore_pend; // restore waits one cycle for registered read
  logic interlock_bad; // interlock forbids current
  logic hard_cond; // steady error condition
  logic temp_lim_active; // temperature limits in force
  logic faults_now; // any raw fault present
  logic mode_fault; // mode press while enabled
  logic warn_blink_on; // warning blink allowed
  logic limit_blink_on; // limit blink allowed
  // indicator registers, gathered into the output struct below
  logic error_lit; // error indicator register
  logic limit_lit; // limit indicator register
  logic on_lit; // output-on indicator register

  // settings memory
  // a separate store so the saved word is untouched by the power-on reset
  tps_store u_store (
    .clk(clk),
    .wr(save_settings),
    .wdata(settings_in),
    .rdata(store_rdata)
  );

  // temperature limits obeyed except with sensor type none
  assign temp_lim_active = !sense.sensor_none;
  // default: joined pins block; inverted: open pins block
  // the same term feeds the steady indicator condition below
  assign interlock_bad = interlock_invert ? !sense.interlock_joined : sense.interlock_joined;
  assign mode_fault = mode_press && out_en;

  // raw fault vector, one bit per shutdown cause
  // a raw fault refuses the on request in the same cycle
  always_comb begin
    next_fault = '0;
    next_fault[tps_pkg::F_THI] = sense.temp_high && temp_lim_active;
    next_fault[tps_pkg::F_TLO] = sense.temp_low && temp_lim_active;
    next_fault[tps_pkg::F_RLIM] = sense.res_limit;
    next_fault[tps_pkg::F_OPEN] = sense.load_open;
    next_fault[tps_pkg::F_SOPEN] = sense.sensor_open;
    next_fault[tps_pkg::F_SSEL] = sense.sensor_sel_change;
    next_fault[tps_pkg::F_SSHORT] = sense.sensor_short;
    next_fault[tps_pkg::F_MODE] = mode_fault;
  end
  assign faults_now = |next_fault;

  // steady-on conditions for both indicators; any single one is enough
  always_comb begin
    // interlock in its blocking state, either polarity
    hard_cond = interlock_bad;
    // chassis too hot, or compliance voltage used up
    hard_cond = hard_cond || sense.internal_over || sense.compliance_over;
    // sensor wiring faults
    hard_cond = hard_cond || sense.sensor_short || sense.sensor_open;
    // window limits; temperature ones skipped without a sensor
    hard_cond = hard_cond || ((sense.temp_high || sense.temp_low) && temp_lim_active);
    hard_cond = hard_cond || sense.res_limit;
  end

  // blink permits: warning needs the output enabled, limiting the request or the drive
  assign warn_blink_on = out_en && sense.internal_warn;
  // drive kept in so limiting still shows in the cycle the request drops
  assign limit_blink_on = sense.current_limit && (out_en || drive_enable);

  // one process per indicator register; the struct only gathers them
  assign leds = '{error_led: error_lit, limit_led: limit_lit, on_led: on_lit};

  // polarity set only by the configuration command
  // kept through faults; only rst or a new command changes it
  always_ff @(posedge clk) begin
    if (rst) begin
      interlock_invert <= 1'b0;
    end else if (hardware_config_command) begin
      // new polarity takes effect on the following cycle
      interlock_invert <= interlock_invert_in;
    end
  end

  // sticky fault flags; a new fault wins over the clearing request
  // a fault that flickers during the press latches again at once
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_flags <= tps_pkg::FAULT_RESET;
    end else if (output_on_req && !faults_now) begin
      // clean request: every cause gone, so all flags drop
      fault_flags <= tps_pkg::FAULT_RESET;
    end else begin
      // set side: or in whatever is raised this cycle
      fault_flags <= fault_flags | next_fault;
    end
  end

  // output request state; power-up forces off
  // off request and faults both win over a simultaneous on request
  always_ff @(posedge clk) begin
    if (rst) begin
      out_en <= 1'b0;
    end else if (faults_now || output_off_req) begin
      // trip or off button
      out_en <= 1'b0;
    end else if (output_on_req) begin
      // accepted only in a cycle with no raw fault
      out_en <= 1'b1;
    end
  end

  // drive: needs request, no latched fault, interlock clear
  // raw faults are looked at too, so a trip cuts drive one cycle sooner
  // interlock is checked live; a bad interlock never latches a flag
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_enable <= 1'b0;
    end else begin
      drive_enable <= out_en && !faults_now && !(|fault_flags) && !interlock_bad;
    end
  end

  // on LED follows the accepted request
  // lit even while the interlock holds the current back
  always_ff @(posedge clk) begin
    if (rst) begin
      on_lit <= 1'b0;
    end else begin
      on_lit <= out_en;
    end
  end

  // clamp is soft: current held at limit, drive stays on
  // the clamp is advisory for the analog loop; it never gates drive
  always_ff @(posedge clk) begin
    if (rst) begin
      current_clamp <= 1'b0;
    end else begin
      current_clamp <= sense.current_limit;
    end
  end

  // mode cycles on each press; default constant current
  // the press itself never waits for the output to drop
  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= tps_pkg::TPS_MODE_ITE;
    end else if (mode_press) begin
      // the fault side of a press is handled by the flag logic
      unique case (mode)
        tps_pkg::TPS_MODE_TEMP: mode <= tps_pkg::TPS_MODE_RES;
        tps_pkg::TPS_MODE_RES: mode <= tps_pkg::TPS_MODE_ITE;
        tps_pkg::TPS_MODE_ITE: mode <= tps_pkg::TPS_MODE_TEMP;
        default: mode <= tps_pkg::TPS_MODE_ITE; // unused code recovers
      endcase
    end
  end

  // free-running blink phase shared by both LEDs so they blink together
  // one counter keeps the two indicators in phase at low cost
  always_ff @(posedge clk) begin
    if (rst) begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end else if (blink_cnt == tps_pkg::CNT_W'(tps_pkg::BLINK_CYCLES - 1)) begin
      // half period done: flip phase
      blink_cnt <= '0;
      blink <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  // error LED: latched error or hard condition steady, warning blinks
  always_ff @(posedge clk) begin
    if (rst) begin
      error_lit <= 1'b0;
    end else if (hard_cond || (|fault_flags)) begin
      // steady: a latched flag keeps it lit after the cause is gone
      error_lit <= 1'b1;
    end else if (warn_blink_on) begin
      // warning only: blink, the output keeps running
      error_lit <= blink;
    end else begin
      // limiting alone or nothing at all
      error_lit <= 1'b0;
    end
  end

  // limit LED: steady on hard condition, blinks while limiting
  always_ff @(posedge clk) begin
    if (rst) begin
      limit_lit <= 1'b0;
    end else if (hard_cond) begin
      // hard condition overrides any blinking
      limit_lit <= 1'b1;
    end else if (limit_blink_on) begin
      // soft limit: blink in step with the error indicator
      limit_lit <= blink;
    end else begin
      // current back under the limit: dark at once
      limit_lit <= 1'b0;
    end
  end

  // power-up restore: read data arrive one cycle after reset
  // the store's registered read costs one extra cycle before reload
  always_ff @(posedge clk) begin
    if (rst) begin
      boot <= 1'b1;
      restore_pend <= 1'b0;
    end else begin
      boot <= 1'b0;
      restore_pend <= boot;
    end
  end

  // settings register, reloaded from the store at power-up
  // a save landing in the reload cycle reaches the store, not this register
  always_ff @(posedge clk) begin
    if (rst) begin
      settings_out <= tps_pkg::SET_RESET;
    end else if (restore_pend) begin
      // word saved before the last power-down
      settings_out <= store_rdata;
    end else if (save_settings) begin
      // panel save shows at once
      settings_out <= settings_in;
    end
  end

  // title display timer after reset
  // counter parks at its end value, so the title shows once per reset
  always_ff @(posedge clk) begin
    if (rst) begin
      title_cnt <= '0;
      title_show <= 1'b1;
    end else if (title_cnt != tps_pkg::CNT_W'(tps_pkg::TITLE_CYCLES)) begin
      title_cnt <= title_cnt + 1'b1;
      title_show <= (title_cnt != tps_pkg::CNT_W'(tps_pkg::TITLE_CYCLES - 1));
    end else begin
      // parked: title stays off until the next reset
      title_show <= 1'b0;
    end
  end

  // short beep at power-up when enabled
  // the enable is read every cycle, so muting cuts a running beep
  always_ff @(posedge clk) begin
    if (rst) begin
      beep_cnt <= '0;
      beep <= 1'b0;
    end else if (beep_cnt != tps_pkg::CNT_W'(tps_pkg::BEEP_CYCLES)) begin
      beep_cnt <= beep_cnt + 1'b1;
      beep <= beeper_enable && (beep_cnt != tps_pkg::CNT_W'(tps_pkg::BEEP_CYCLES - 1));
    end else begin
      // parked: silent until the next reset
      beep <= 1'b0;
    end
  end
endmodule

// ===== testbench/tps_checker_asserts.sv
`timescale 1ns/1ps
// port-level checker for the protection block
module tps_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs
  input wire tps_pkg::tps_sense_t sense,
  input wire logic output_on_req,
  input wire logic mode_press,
  // outputs
  input wire tps_pkg::tps_leds_t leds,
  input wire logic drive_enable,
  input wire logic current_clamp,
  input wire logic title_show,
  input wire logic beep,
  input wire tps_pkg::tps_mode_t mode,
  input wire logic [tps_pkg::NFAULT-1:0] fault_flags
);
  // trips that do not depend on mode or sensor type
  wire logic trip = sense.load_open | sense.sensor_open | sense.sensor_short | sense.res_limit
    | sense.sensor_sel_change;
  // any raw shutdown cause; a clear is only legal without one
  wire logic any_raw = trip | sense.temp_high | sense.temp_low | mode_press;
  // steady-light causes other than the interlock
  wire logic hard = sense.internal_over | sense.compliance_over | trip | sense.temp_high | sense.temp_low;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  trip_off_a: assert property (trip |-> ##2 !drive_enable)
    else $error("drive left on after a trip");
  trip_led_a: assert property (trip |-> ##2 leds.error_led)
    else $error("error led dark after a trip");
  open_flag_a: assert property (sense.load_open |=> fault_flags[tps_pkg::F_OPEN])
    else $error("open load not latched");
  flags_hold_a: assert property (!output_on_req |=>
    (fault_flags & $past(fault_flags)) == $past(fault_flags))
    else $error("fault flag dropped without request");
  clean_clear_a: assert property (output_on_req && !any_raw |=> fault_flags == '0)
    else $error("flags kept after clean request");
  flag_block_a: assert property (fault_flags != '0 |=> !drive_enable)
    else $error("drive on with a latched fault");
  clamp_follow_a: assert property (1'b1 |=> current_clamp == $past(sense.current_limit))
    else $error("clamp does not follow limit");
  both_steady_a: assert property ((sense.sensor_short || sense.internal_over || sense.compliance_over)[*2]
    |-> ##1 (leds.error_led && leds.limit_led))
    else $error("hard condition not shown on both leds");
  limit_dark_a: assert property ((drive_enable && !sense.current_limit && !hard && !sense.internal_warn)[*3]
    |-> !leds.limit_led)
    else $error("limit led lit with no limiting");
  power_up_a: assert property (disable iff (1'b0) rst |=> title_show && !drive_enable && !beep
    && mode == tps_pkg::TPS_MODE_ITE)
    else $error("wrong power-up state");
  mode_step_a: assert property (mode_press |=> mode == ($past(mode) == tps_pkg::TPS_MODE_ITE ?
    tps_pkg::TPS_MODE_TEMP : tps_pkg::tps_mode_t'($past(mode) + 2'h1)))
    else $error("mode did not advance");
endmodule
bind tps_top tps_checker i_chk (.*);

// ===== testbench/tps_far_model.sv
`timescale 1ns/1ps
// comparator bank in front of the block
module tps_far_model (
  // clock
  input wire logic clk,
  // conditions the bench wants reported
  input wire tps_pkg::tps_sense_t want,
  // comparator levels
  output tps_pkg::tps_sense_t sense
);
  // comparators settle one clock after the analog change
  always_ff @(posedge clk) begin
    sense <= want;
  end
endmodule

// ===== testbench/tb_tec_output_protection_status.sv
`timescale 1ns/1ps
// self-checking bench for the protection block
module tb_tec_output_protection_status;
  logic clk = 1'b0;
  logic rst = 1'b1;
  tps_pkg::tps_sense_t want = '0;
  tps_pkg::tps_sense_t sense;
  logic on_rq = 1'b0, off_rq = 1'b0, mp = 1'b0, bpe = 1'b1, hwc = 1'b0, inv = 1'b0, sv = 1'b0;
  logic [tps_pkg::SET_W-1:0] sin = 16'h0000;
  logic [tps_pkg::SET_W-1:0] sout;
  tps_pkg::tps_leds_t leds;
  logic drv, clamp, title, beep;
  tps_pkg::tps_mode_t mode;
  logic [tps_pkg::NFAULT-1:0] flags;
  int n_mismatch = 0, cmp_count = 0, cycles = 0;
  // sense bit of each shutdown cause and the flag it latches
  int sb[7] = '{12, 11, 10, 9, 8, 7, 6};
  int fb[7] = '{tps_pkg::F_THI, tps_pkg::F_TLO, tps_pkg::F_RLIM, tps_pkg::F_OPEN, tps_pkg::F_SOPEN,
    tps_pkg::F_SSHORT, tps_pkg::F_SSEL};
  tps_far_model i_far (.clk(clk), .want(want), .sense(sense));
  tps_top i_dut (.clk(clk), .rst(rst), .sense(sense), .output_on_req(on_rq), .output_off_req(off_rq),
    .mode_press(mp), .beeper_enable(bpe), .hardware_config_command(hwc), .interlock_invert_in(inv),
    .save_settings(sv), .settings_in(sin), .leds(leds), .drive_enable(drv), .current_clamp(clamp),
    .title_show(title), .beep(beep), .settings_out(sout), .mode(mode), .fault_flags(flags));
  initial forever #4 clk = ~clk;
  task automatic end_of_test();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard: whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 4000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected {error, limit} pair from the status table; phase is the blink level,
  // low for the whole run since the first toggle comes long after it ends
  function automatic logic [1:0] led_exp(input logic hard, input logic latched, input logic warn,
    input logic limiting, input logic enabled, input logic phase);
    if (hard) begin
      return 2'h3;
    end
    return {latched || (enabled && warn && phase), enabled && limiting && phase};
  endfunction
  // step past the edges so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle press of a button signal
  task automatic press_on();
    @(posedge clk) on_rq <= 1'b1;
    @(posedge clk) on_rq <= 1'b0;
    cyc(3);
  endtask
  task automatic press_mode();
    @(posedge clk) mp <= 1'b1;
    @(posedge clk) mp <= 1'b0;
    cyc(2);
  endtask
  initial begin
    void'($urandom(32'h02ae));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    chk(title, 1'b1);
    chk(drv, 1'b0);
    chk(beep, 1'b1);
    chk(mode, tps_pkg::TPS_MODE_ITE);
    @(posedge clk) sin <= 16'($urandom());
    sv <= 1'b1;
    @(posedge clk) sv <= 1'b0;
    cyc(2);
    chk(sout, sin);
    press_on();
    chk(drv, 1'b1);
    chk(leds, 3'h1);
    // soft limit leaves the output running
    @(posedge clk) want.current_limit <= 1'b1;
    cyc(5);
    chk(clamp, 1'b1);
    chk(drv, 1'b1);
    chk(leds.error_led, 1'b0);
    chk({leds.error_led, leds.limit_led}, led_exp(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
    @(posedge clk) want <= '0;
    cyc(5);
    chk(leds.limit_led, 1'b0);
    // warning temperature while running: error blinks, drive stays on
    @(posedge clk) want.internal_warn <= 1'b1;
    cyc(5);
    chk({drv, leds.error_led, leds.limit_led}, {1'b1, led_exp(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0)});
    @(posedge clk) want <= '0;
    cyc(3);
    // each trip held for a random short time, then cleared
    for (int i = 0; i < 7; i++) begin
      @(posedge clk) want[sb[i]] <= 1'b1;
      repeat ($urandom_range(4, 1)) @(posedge clk);
      want <= '0;
      cyc(5);
      chk(drv, 1'b0);
      chk(leds.error_led, 1'b1);
      chk(flags[fb[i]], 1'b1);
      press_on();
      chk(flags, 8'h00);
      chk({drv, leds.error_led}, 2'h2);
    end
    // no sensor: temperature limits ignored
    @(posedge clk) want <= 13'h1000 | 13'h0001;
    cyc(5);
    chk({drv, flags}, 9'h100);
    // hard conditions light both leds steadily
    for (int j = 0; j < 2; j++) begin
      @(posedge clk) want <= j ? 13'h0010 : 13'h0004;
      cyc(5);
      chk({leds.error_led, leds.limit_led}, led_exp(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0));
      @(posedge clk) want <= '0;
      cyc(3);
    end
    press_on();
    press_mode();
    chk(mode, tps_pkg::TPS_MODE_TEMP);
    chk({drv, flags[tps_pkg::F_MODE]}, 2'h1);
    press_mode();
    press_mode();
    chk(mode, tps_pkg::TPS_MODE_ITE);
    // inverted polarity: pins must be joined
    @(posedge clk) hwc <= 1'b1;
    inv <= 1'b1;
    @(posedge clk) hwc <= 1'b0;
    press_on();
    chk(drv, 1'b0);
    @(posedge clk) want.interlock_joined <= 1'b1;
    cyc(3);
    press_on();
    chk(drv, 1'b1);
    @(posedge clk) hwc <= 1'b1;
    inv <= 1'b0;
    @(posedge clk) hwc <= 1'b0;
    press_on();
    chk(drv, 1'b0);
    @(posedge clk) want <= '0;
    cyc(3);
    press_on();
    chk(drv, 1'b1);
    // second power-up with the beeper muted: saved word returns, output off
    @(posedge clk) rst <= 1'b1;
    bpe <= 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    chk(sout, sin);
    chk({title, drv, leds.on_led, beep}, 4'h8);
    chk(flags, 8'h00);
    end_of_test();
  end
endmodule
